// ==== src/iofd_defines.svh ====
/*
  Constants of the digital I/O port: parameter indices, field positions, reset values and times.
  Assumes inclusion by bare name from the lamp driver and port files.
*/
`ifndef IOFD_DEFINES_SVH
`define IOFD_DEFINES_SVH
`define IOFD_CLK_HZ 40000000
`define IOFD_IDX_OUT_IMAGE 4'h0
`define IOFD_IDX_IN_IMAGE 4'h1
`define IOFD_IDX_FAULT_OUT 4'h2
`define IOFD_IDX_FAULT_IN 4'h3
`define IOFD_IDX_GROUP_CFG 4'h4
`define IOFD_IDX_FALLBACK 4'h5
`define IOFD_IDX_CONN_MON 4'h6
`define IOFD_IDX_DIAG_EN 4'h7
`define IOFD_IDX_DIAG_MSG 4'h8
`define IOFD_IDX_OUT_USE 4'h9
`define IOFD_CFG_FREEZE_BIT 6
`define IOFD_CONN_SYNC 2'b00
`define IOFD_CONN_ASYNC 2'b10
`define IOFD_FW_SHORT 0
`define IOFD_FW_OVERLOAD 1
`define IOFD_FW_SUP_OVER 4
`define IOFD_FW_SUP_UNDER 5
`define IOFD_FLT_OUT_SHORT 0
`define IOFD_FLT_OUT_OVER 1
`define IOFD_FLT_ACT_OVER 2
`define IOFD_FLT_ACT_UNDER 3
`define IOFD_FLT_SEN_OVER 4
`define IOFD_FLT_SEN_UNDER 5
`define IOFD_FLT_OVERTEMP 6
`define IOFD_FLT_SURGE 7
`define IOFD_RST_GROUP_CFG 16'h0000
`define IOFD_RST_FALLBACK 16'h0000
`define IOFD_RST_OUT_USE 16'h0000
`define IOFD_RST_CONN_MON 2'b00
`define IOFD_RST_DIAG_EN 1'b1
`define IOFD_WDOG_US 10
`define IOFD_BOOT_US 50
`define IOFD_BLINK_MS 250
`define IOFD_WDOG_CYCLES ((`IOFD_WDOG_US * `IOFD_CLK_HZ) / 1000000)
`define IOFD_BOOT_CYCLES ((`IOFD_BOOT_US * `IOFD_CLK_HZ + 999999) / 1000000)
`define IOFD_BLINK_CYCLES (`IOFD_BLINK_MS * (`IOFD_CLK_HZ / 1000))
`endif

// ==== src/iofd_pkg.sv ====
/*
  Types of the digital I/O port.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package iofd_pkg;
  typedef logic [15:0] iofd_image_t;
  typedef logic [31:0] iofd_word_t;
  typedef enum logic {IOFD_LINK_OK, IOFD_LINK_SUBST} iofd_link_t;
endpackage

// ==== src/iofd_lamp_if.sv ====
/*
  Carrier between the port core and its lamp driver.
  Assumes both ends share sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
interface iofd_lamp_if;
  logic bootDone;
  logic fwUpdate;
  logic diagPending;
  logic lampStatus;
  logic lampFault;
  logic lampReadyGreen;
  logic lampReadyYellow;
  modport core (output bootDone, output fwUpdate, output diagPending,
    input lampStatus, input lampFault, input lampReadyGreen, input lampReadyYellow);
  modport drv (input bootDone, input fwUpdate, input diagPending,
    output lampStatus, output lampFault, output lampReadyGreen, output lampReadyYellow);
endinterface
`default_nettype wire

// ==== src/iofd_sync.sv ====
/*
  Two-stage synchroniser for a bus of independent levels.
  Assumes each bit is a slow level; words are not kept coherent.
*/
`timescale 1ns/10ps
`default_nettype none
module iofd_sync #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '0;
      syncOut <= '0;
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule
`default_nettype wire

// ==== src/iofd_lamp.sv ====
/*
  Lamp driver: status, fault and two-colour ready lamp with flashing.
  Assumes inputs from logic in the sys_clk domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "iofd_defines.svh"
module iofd_lamp #(
  parameter int BLINK_CYCLES = `IOFD_BLINK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  iofd_lamp_if.drv lamp
);
  logic [31:0] blinkCnt;
  logic blinkPhase;
  logic [31:0] next_blinkCnt;
  logic next_blinkPhase;

  always_comb begin
    next_blinkCnt = blinkCnt + 32'h1;
    next_blinkPhase = blinkPhase;
    if (!lamp.fwUpdate) begin
      next_blinkCnt = '0;
      next_blinkPhase = 1'b1;
    end else if (blinkCnt >= 32'(BLINK_CYCLES - 1)) begin
      next_blinkCnt = '0;
      next_blinkPhase = ~blinkPhase;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      blinkCnt <= '0;
      blinkPhase <= 1'b1;
      lamp.lampStatus <= 1'b0;
      lamp.lampFault <= 1'b0;
      lamp.lampReadyGreen <= 1'b0;
      lamp.lampReadyYellow <= 1'b0;
    end else begin
      blinkCnt <= next_blinkCnt;
      blinkPhase <= next_blinkPhase;
      lamp.lampStatus <= lamp.diagPending;
      lamp.lampFault <= lamp.diagPending;
      lamp.lampReadyGreen <= lamp.bootDone & ~lamp.fwUpdate;
      lamp.lampReadyYellow <= lamp.fwUpdate & next_blinkPhase;
    end
  end
endmodule
`default_nettype wire

// ==== src/iofd_port.sv ====
/*
  Sixteen-channel digital I/O port with substitute values and fault reporting.
  Assumes the fieldbus controller logic shares sys_clk; channel pins and fault
  sense inputs are asynchronous and pass through synchronisers.
*/
`timescale 1ns/10ps
`default_nettype none
`include "iofd_defines.svh"
module iofd_port
  import iofd_pkg::*;
#(
  parameter int WDOG_CYCLES = `IOFD_WDOG_CYCLES,
  parameter int BOOT_CYCLES = `IOFD_BOOT_CYCLES,
  parameter int BLINK_CYCLES = `IOFD_BLINK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic linkUp,
  input wire logic cycleStrobe,
  input wire iofd_image_t cycleOutImage,
  output iofd_image_t cycleInImage,
  input wire logic cfgPhase,
  input wire logic fwUpdate,
  input wire logic paramWrEn,
  input wire logic paramRdEn,
  input wire logic [3:0] paramIdx,
  input wire iofd_word_t paramWrData,
  output iofd_word_t paramRdData,
  output logic paramAck,
  output logic paramErr,
  output logic diagPending,
  input wire logic [15:0] lineIn,
  output logic [15:0] lineOut,
  output logic [15:0] lineOe_n,
  input wire logic [7:0] faultIn,
  output logic lampStatus,
  output logic lampFault,
  output logic lampReadyGreen,
  output logic lampReadyYellow
);
  iofd_lamp_if lampBus ();
  iofd_image_t sensed;
  logic [7:0] faultSync;

  iofd_sync #(.WIDTH(16)) senseSync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .asyncIn(lineIn),
    .syncOut(sensed)
  );

  iofd_sync #(.WIDTH(8)) faultSyncer (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .asyncIn(faultIn),
    .syncOut(faultSync)
  );

  iofd_lamp #(.BLINK_CYCLES(BLINK_CYCLES)) lampDrv (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .lamp(lampBus.drv)
  );

  // Builds a fault word from the two output bits and the two supply bits.
  function automatic iofd_word_t faultWord(input logic shortBit, input logic overBit,
                                           input logic supOver, input logic supUnder);
    iofd_word_t w;
    w = '0;
    w[`IOFD_FW_SHORT] = shortBit;
    w[`IOFD_FW_OVERLOAD] = overBit;
    w[`IOFD_FW_SUP_OVER] = supOver;
    w[`IOFD_FW_SUP_UNDER] = supUnder;
    return w;
  endfunction

  // Configuration and parameter access state.
  iofd_image_t groupCfg, next_groupCfg;
  iofd_image_t fallback, next_fallback;
  iofd_image_t outUse, next_outUse;
  iofd_image_t outLatch, next_outLatch;
  logic [1:0] connMon, next_connMon;
  logic diagEn, next_diagEn;
  logic [7:0] diagStore, next_diagStore;
  iofd_word_t next_paramRdData;
  logic next_paramAck, next_paramErr;
  iofd_word_t faultOutWord, faultInWord;

  // Link supervision and pin state.
  iofd_link_t linkState, next_linkState;
  logic [15:0] wdogCnt, next_wdogCnt;
  iofd_image_t next_lineOut, next_cycleInImage;
  logic [15:0] bootCnt, next_bootCnt;
  logic bootDone, next_bootDone;
  logic freeze;
  logic wdogExpired;

  // The output group carries output and actuator supply faults; the input group the sensor supply.
  assign faultOutWord = faultWord(faultSync[`IOFD_FLT_OUT_SHORT], faultSync[`IOFD_FLT_OUT_OVER],
    faultSync[`IOFD_FLT_ACT_OVER], faultSync[`IOFD_FLT_ACT_UNDER]);
  assign faultInWord = faultWord(1'b0, 1'b0,
    faultSync[`IOFD_FLT_SEN_OVER], faultSync[`IOFD_FLT_SEN_UNDER]);
  assign freeze = groupCfg[`IOFD_CFG_FREEZE_BIT];
  assign diagPending = |diagStore;

  always_comb begin
    next_groupCfg = groupCfg;
    next_fallback = fallback;
    next_outUse = outUse;
    next_outLatch = outLatch;
    next_connMon = connMon;
    next_diagEn = diagEn;
    next_paramRdData = paramRdData;
    next_paramAck = paramRdEn | paramWrEn;
    next_paramErr = 1'b0;
    if (cycleStrobe && linkUp) begin
      next_outLatch = cycleOutImage;
    end
    if (paramWrEn) begin
      if (paramIdx == `IOFD_IDX_OUT_IMAGE) begin
        next_outLatch = paramWrData[15:0];
      end else if (paramIdx == `IOFD_IDX_GROUP_CFG) begin
        next_groupCfg = paramWrData[15:0];
      end else if (paramIdx == `IOFD_IDX_FALLBACK) begin
        next_fallback = paramWrData[15:0];
      end else if (paramIdx == `IOFD_IDX_OUT_USE) begin
        next_outUse = paramWrData[15:0];
      end else if (paramIdx == `IOFD_IDX_CONN_MON) begin
        if (paramWrData[1:0] == `IOFD_CONN_SYNC || paramWrData[1:0] == `IOFD_CONN_ASYNC) begin
          next_connMon = paramWrData[1:0];
        end else begin
          next_paramErr = 1'b1;
        end
      end else if (paramIdx == `IOFD_IDX_DIAG_EN) begin
        if (cfgPhase) begin
          next_diagEn = paramWrData[0];
        end else begin
          next_paramErr = 1'b1;
        end
      end else if (paramIdx == `IOFD_IDX_DIAG_MSG) begin
        next_paramErr = 1'b0;
      end else begin
        next_paramErr = 1'b1;
      end
    end else if (paramRdEn) begin
      if (paramIdx == `IOFD_IDX_OUT_IMAGE) begin
        next_paramRdData = {16'h0000, outLatch};
      end else if (paramIdx == `IOFD_IDX_IN_IMAGE) begin
        next_paramRdData = {16'h0000, cycleInImage};
      end else if (paramIdx == `IOFD_IDX_FAULT_OUT) begin
        next_paramRdData = faultOutWord;
      end else if (paramIdx == `IOFD_IDX_FAULT_IN) begin
        next_paramRdData = faultInWord;
      end else if (paramIdx == `IOFD_IDX_GROUP_CFG) begin
        next_paramRdData = {16'h0000, groupCfg};
      end else if (paramIdx == `IOFD_IDX_FALLBACK) begin
        next_paramRdData = {16'h0000, fallback};
      end else if (paramIdx == `IOFD_IDX_OUT_USE) begin
        next_paramRdData = {16'h0000, outUse};
      end else if (paramIdx == `IOFD_IDX_CONN_MON) begin
        next_paramRdData = {30'h00000000, connMon};
      end else if (paramIdx == `IOFD_IDX_DIAG_EN) begin
        next_paramRdData = {31'h00000000, diagEn};
      end else if (paramIdx == `IOFD_IDX_DIAG_MSG) begin
        next_paramRdData = {24'h000000, diagStore};
      end else begin
        next_paramRdData = '0;
        next_paramErr = 1'b1;
      end
    end
  end

  // A fault present in the clearing cycle stays stored, so no entry is lost.
  always_comb begin
    next_diagStore = diagStore;
    if (paramWrEn && paramIdx == `IOFD_IDX_DIAG_MSG) begin
      next_diagStore = diagStore & ~paramWrData[7:0];
    end
    if (diagEn) begin
      next_diagStore = next_diagStore | faultSync;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      groupCfg <= `IOFD_RST_GROUP_CFG;
      fallback <= `IOFD_RST_FALLBACK;
      outUse <= `IOFD_RST_OUT_USE;
      outLatch <= '0;
      connMon <= `IOFD_RST_CONN_MON;
      diagEn <= `IOFD_RST_DIAG_EN;
      diagStore <= '0;
      paramRdData <= '0;
      paramAck <= 1'b0;
      paramErr <= 1'b0;
    end else begin
      groupCfg <= next_groupCfg;
      fallback <= next_fallback;
      outUse <= next_outUse;
      outLatch <= next_outLatch;
      connMon <= next_connMon;
      diagEn <= next_diagEn;
      diagStore <= next_diagStore;
      paramRdData <= next_paramRdData;
      paramAck <= next_paramAck;
      paramErr <= next_paramErr;
    end
  end

  // The watchdog applies only in synchronous mode; asynchronous mode trusts linkUp alone.
  assign wdogExpired = (connMon == `IOFD_CONN_SYNC) && (wdogCnt >= 16'(WDOG_CYCLES - 1));

  always_comb begin
    next_linkState = linkState;
    next_wdogCnt = wdogCnt;
    if (cycleStrobe) begin
      next_wdogCnt = '0;
    end else if (!wdogExpired) begin
      next_wdogCnt = wdogCnt + 16'h0001;
    end
    case (linkState)
      IOFD_LINK_OK: begin
        if (!linkUp || (wdogExpired && !cycleStrobe)) begin
          next_linkState = IOFD_LINK_SUBST;
        end
      end
      IOFD_LINK_SUBST: begin
        if (linkUp && cycleStrobe) begin
          next_linkState = IOFD_LINK_OK;
        end
      end
      default: next_linkState = IOFD_LINK_SUBST;
    endcase
  end

  always_comb begin
    next_lineOut = outLatch;
    if (next_linkState == IOFD_LINK_SUBST) begin
      if (freeze) begin
        next_lineOut = lineOut;
      end else begin
        next_lineOut = fallback;
      end
    end
    // Input channels are never driven, whatever the image holds.
    next_lineOut = next_lineOut & outUse;
    next_cycleInImage = cycleInImage;
    if (cycleStrobe) begin
      next_cycleInImage = (lineOut & outUse) | (sensed & ~outUse);
    end
    next_bootCnt = bootCnt;
    next_bootDone = bootDone;
    if (bootCnt >= 16'(BOOT_CYCLES - 1)) begin
      next_bootDone = 1'b1;
    end else begin
      next_bootCnt = bootCnt + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      linkState <= IOFD_LINK_SUBST;
      wdogCnt <= '0;
      lineOut <= '0;
      lineOe_n <= 16'hffff;
      cycleInImage <= '0;
      bootCnt <= '0;
      bootDone <= 1'b0;
    end else begin
      linkState <= next_linkState;
      wdogCnt <= next_wdogCnt;
      lineOut <= next_lineOut;
      lineOe_n <= ~outUse;
      cycleInImage <= next_cycleInImage;
      bootCnt <= next_bootCnt;
      bootDone <= next_bootDone;
    end
  end

  assign lampBus.bootDone = bootDone;
  assign lampBus.fwUpdate = fwUpdate;
  assign lampBus.diagPending = diagPending;
  assign lampStatus = lampBus.lampStatus;
  assign lampFault = lampBus.lampFault;
  assign lampReadyGreen = lampBus.lampReadyGreen;
  assign lampReadyYellow = lampBus.lampReadyYellow;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence linkBack;
    linkState == IOFD_LINK_SUBST && linkUp && cycleStrobe;
  endsequence

  sequence resumeDrive;
    linkState == IOFD_LINK_OK ##1 lineOut == ($past(outLatch) & $past(outUse));
  endsequence

  conn_code_a: assert property (connMon == `IOFD_CONN_SYNC || connMon == `IOFD_CONN_ASYNC)
    else $error("connection monitor holds an unsupported code");
  link_drop_a: assert property (!linkUp |=> linkState == IOFD_LINK_SUBST)
    else $error("link loss did not enter substitute state");
  freeze_hold_a: assert property ((linkState == IOFD_LINK_SUBST && freeze && !linkUp
    && $stable(outUse)) |=> $stable(lineOut))
    else $error("frozen outputs changed");
  fallback_load_a: assert property ((!linkUp && !freeze) |=> lineOut == ($past(fallback)
    & $past(outUse)))
    else $error("outputs not loaded from fallback value");
  out_map_a: assert property ((linkState == IOFD_LINK_OK && linkUp && !wdogExpired)
    |=> lineOut == ($past(outLatch) & $past(outUse)))
    else $error("output lines differ from the output image");
  echo_map_a: assert property (cycleStrobe |=> cycleInImage == (($past(lineOut) & $past(outUse))
    | ($past(sensed) & ~$past(outUse))))
    else $error("input image does not reflect lines");
  // A link that drops again straight after recovery rightly falls back to substitutes.
  recover_a: assert property (linkBack ##1 linkUp |-> resumeDrive)
    else $error("outputs did not resume from new image");
  fault_word_a: assert property (faultOutWord[31:6] == 26'h0 && faultOutWord[3:2] == 2'b00
    && faultInWord[1:0] == 2'b00)
    else $error("reserved fault word bits set");
  diag_lamp_a: assert property (diagPending |=> lampFault && lampStatus)
    else $error("stored diagnostics did not light lamps");
  diag_off_a: assert property ((!diagEn && !(paramWrEn && paramIdx == `IOFD_IDX_DIAG_MSG))
    |=> diagStore == $past(diagStore))
    else $error("disabled diagnostics stored an entry");
  wdog_trip_a: assert property ((linkState == IOFD_LINK_OK && wdogExpired && !cycleStrobe)
    |=> linkState == IOFD_LINK_SUBST)
    else $error("watchdog expiry ignored");
  boot_green_a: assert property ((bootDone && !fwUpdate) |=> lampReadyGreen)
    else $error("ready lamp not green after startup");
  update_amber_a: assert property (fwUpdate |=> !lampReadyGreen)
    else $error("ready lamp green during update");
  drive_dir_a: assert property (1'b1 |=> (lineOut & lineOe_n) == 16'h0000)
    else $error("input channel driven");
endmodule
`default_nettype wire

// ==== verification/iofd_master_model.sv ====
/*
  Behavioural fieldbus master that sends cyclic frames with an output image.
  Assumes it shares sys_clk with the port and is steered by the testbench.
*/
`timescale 1ns/10ps
`default_nettype none
module iofd_master_model
  import iofd_pkg::*;
#(
  parameter int PERIOD = 4
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic running,
  input wire logic linkEn,
  input wire iofd_image_t txImage,
  input wire iofd_image_t useMask,
  output logic linkUp,
  output logic cycleStrobe,
  output iofd_image_t cycleOutImage
);
  logic [7:0] cnt;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 8'h00;
      linkUp <= 1'b0;
      cycleStrobe <= 1'b0;
      cycleOutImage <= 16'h0000;
    end else begin
      linkUp <= linkEn;
      cycleStrobe <= 1'b0;
      // Between frames the image is not valid, so it keeps changing.
      cycleOutImage <= ~cycleOutImage;
      cnt <= (cnt == 8'(PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
      if (running && cnt == 8'h00) begin
        cycleStrobe <= 1'b1;
        cycleOutImage <= txImage & useMask;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/test_io_image_fallback_diag.sv ====
/*
  Self-checking bench for the I/O port: parameter table, cyclic images,
  substitute values, faults and lamps.
  Assumes the master model drives the cyclic link and short counts in the port.
*/
`timescale 1ns/10ps
`default_nettype none
module test_io_image_fallback_diag;
  import iofd_pkg::*;
  typedef struct {logic wr; logic [3:0] idx; iofd_word_t d; logic err; iofd_word_t rd;} iofd_row_t;
  iofd_row_t rows[18] = '{'{1'b0, 4'h7, 32'h0, 1'b0, 32'h1}, '{1'b0, 4'h6, 32'h0, 1'b0, 32'h0},
    '{1'b0, 4'h4, 32'h0, 1'b0, 32'h0}, '{1'b0, 4'h5, 32'h0, 1'b0, 32'h0},
    '{1'b0, 4'h9, 32'h0, 1'b0, 32'h0}, '{1'b1, 4'h6, 32'h1, 1'b1, 32'h0},
    '{1'b1, 4'h6, 32'h3, 1'b1, 32'h0}, '{1'b0, 4'h6, 32'h0, 1'b0, 32'h0},
    '{1'b1, 4'h6, 32'h2, 1'b0, 32'h0}, '{1'b0, 4'h6, 32'h0, 1'b0, 32'h2},
    '{1'b1, 4'h6, 32'h0, 1'b0, 32'h0}, '{1'b1, 4'h1, 32'h0, 1'b1, 32'h0},
    '{1'b1, 4'h2, 32'h0, 1'b1, 32'h0}, '{1'b1, 4'h3, 32'h0, 1'b1, 32'h0},
    '{1'b0, 4'ha, 32'h0, 1'b1, 32'h0}, '{1'b1, 4'h7, 32'h0, 1'b1, 32'h0},
    '{1'b1, 4'h9, 32'hffff, 1'b0, 32'h0}, '{1'b1, 4'h5, 32'h3c0f, 1'b0, 32'h0}};
  logic [7:0] outMap[8] = '{8'h01, 8'h02, 8'h10, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] inMap[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h20, 8'h00, 8'h00};
  logic sys_clk, arst_n, linkUp, cycleStrobe, cfgPhase, fwUpdate, paramWrEn, paramRdEn;
  logic paramAck, paramErr, diagPending, lampStatus, lampFault, lampReadyGreen;
  logic lampReadyYellow, running, linkEn;
  logic [3:0] paramIdx;
  iofd_word_t paramWrData, paramRdData, rd;
  iofd_image_t cycleOutImage, cycleInImage, txImage, useMask, sense, lineIn, lineOut, lineOe_n;
  logic [7:0] faultIn;
  logic err, prevYellow;
  int numErrors, nCompared, toggles;
  // The pin sees the port's driver where enabled, otherwise the sensor.
  assign lineIn = (~lineOe_n & lineOut) | (lineOe_n & sense);
  iofd_port #(.WDOG_CYCLES(8), .BOOT_CYCLES(4), .BLINK_CYCLES(4)) dut (.sys_clk(sys_clk),
    .arst_n(arst_n), .linkUp(linkUp), .cycleStrobe(cycleStrobe), .cycleOutImage(cycleOutImage),
    .cycleInImage(cycleInImage), .cfgPhase(cfgPhase), .fwUpdate(fwUpdate),
    .paramWrEn(paramWrEn), .paramRdEn(paramRdEn), .paramIdx(paramIdx),
    .paramWrData(paramWrData), .paramRdData(paramRdData), .paramAck(paramAck),
    .paramErr(paramErr), .diagPending(diagPending), .lineIn(lineIn), .lineOut(lineOut),
    .lineOe_n(lineOe_n), .faultIn(faultIn), .lampStatus(lampStatus), .lampFault(lampFault),
    .lampReadyGreen(lampReadyGreen), .lampReadyYellow(lampReadyYellow));
  iofd_master_model #(.PERIOD(4)) master (.sys_clk(sys_clk), .arst_n(arst_n),
    .running(running), .linkEn(linkEn), .txImage(txImage), .useMask(useMask),
    .linkUp(linkUp), .cycleStrobe(cycleStrobe), .cycleOutImage(cycleOutImage));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic access(input logic wr, input logic [3:0] idx, input iofd_word_t d);
    @(posedge sys_clk);
    paramWrEn <= wr;
    paramRdEn <= ~wr;
    paramIdx <= idx;
    paramWrData <= d;
    // The request is taken at this edge; the acknowledge stands for the cycle after it.
    @(posedge sys_clk);
    paramWrEn <= 1'b0;
    paramRdEn <= 1'b0;
    #1;
    check("paramAck", 32'h1, 32'(paramAck));
    rd = paramRdData;
    err = paramErr;
  endtask
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic finishTest();
    $display("compared %0d mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    numErrors++;
    finishTest();
  end
  initial begin
    {arst_n, cfgPhase, fwUpdate, paramWrEn, paramRdEn, running, linkEn} = 7'h00;
    {paramIdx, paramWrData, faultIn} = '0;
    {txImage, useMask, sense} = '0;
    repeat (4) @(posedge sys_clk);
    #1;
    check("lineOe_n", 32'hffff, 32'(lineOe_n));
    check("lineOut", 32'h0, 32'(lineOut));
    @(posedge sys_clk);
    arst_n <= 1'b1;
    wait_cycles(10);
    check("lampReadyGreen", 32'h1, 32'(lampReadyGreen));
    for (int i = 0; i < 18; i++) begin
      access(rows[i].wr, rows[i].idx, rows[i].d);
      check("paramErr", 32'(rows[i].err), 32'(err));
      if (!rows[i].wr && !rows[i].err) check("paramRdData", rows[i].rd, rd);
    end
    @(posedge sys_clk);
    useMask <= 16'hffff;
    txImage <= 16'ha5c3;
    running <= 1'b1;
    linkEn <= 1'b1;
    wait_cycles(12);
    check("lineOut", 32'ha5c3, 32'(lineOut));
    check("lineOe_n", 32'h0, 32'(lineOe_n));
    check("cycleInImage", 32'ha5c3, 32'(cycleInImage));
    @(posedge sys_clk);
    running <= 1'b0;
    wait_cycles(14);
    check("lineOut", 32'h3c0f, 32'(lineOut));
    @(posedge sys_clk);
    txImage <= 16'h1234;
    running <= 1'b1;
    wait_cycles(12);
    check("lineOut", 32'h1234, 32'(lineOut));
    access(1'b1, 4'h6, 32'h2);
    @(posedge sys_clk);
    running <= 1'b0;
    wait_cycles(20);
    check("lineOut", 32'h1234, 32'(lineOut));
    @(posedge sys_clk);
    running <= 1'b1;
    access(1'b1, 4'h6, 32'h0);
    access(1'b1, 4'h4, 32'h40);
    @(posedge sys_clk);
    linkEn <= 1'b0;
    wait_cycles(6);
    check("lineOut", 32'h1234, 32'(lineOut));
    @(posedge sys_clk);
    linkEn <= 1'b1;
    access(1'b1, 4'h4, 32'h0);
    access(1'b1, 4'h9, 32'h00ff);
    @(posedge sys_clk);
    useMask <= 16'h00ff;
    sense <= 16'h5a5a;
    txImage <= 16'ha5c3;
    wait_cycles(12);
    check("lineOe_n", 32'hff00, 32'(lineOe_n));
    check("lineOut", 32'h00c3, 32'(lineOut));
    check("cycleInImage", 32'h5ac3, 32'(cycleInImage));
    @(posedge sys_clk);
    linkEn <= 1'b0;
    wait_cycles(6);
    check("lineOut", 32'h000f, 32'(lineOut));
    @(posedge sys_clk);
    linkEn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      faultIn <= 8'h01 << i;
      wait_cycles(6);
      access(1'b0, 4'h2, 32'h0);
      check("outFaultWord", 32'(outMap[i]), rd);
      access(1'b0, 4'h3, 32'h0);
      check("inFaultWord", 32'(inMap[i]), rd);
      access(1'b0, 4'h8, 32'h0);
      check("storedDiag", 32'h1 << i, rd);
      check("diagPending", 32'h1, 32'(diagPending));
      check("lampFault", 32'h1, 32'(lampFault));
      check("lampStatus", 32'h1, 32'(lampStatus));
      @(posedge sys_clk);
      faultIn <= 8'h00;
      wait_cycles(4);
      access(1'b1, 4'h8, 32'hff);
      wait_cycles(2);
      check("diagPending", 32'h0, 32'(diagPending));
      check("lampFault", 32'h0, 32'(lampFault));
    end
    @(posedge sys_clk);
    cfgPhase <= 1'b1;
    access(1'b1, 4'h7, 32'h0);
    check("paramErr", 32'h0, 32'(err));
    @(posedge sys_clk);
    cfgPhase <= 1'b0;
    faultIn <= 8'h40;
    wait_cycles(6);
    check("diagPending", 32'h0, 32'(diagPending));
    @(posedge sys_clk);
    fwUpdate <= 1'b1;
    wait_cycles(3);
    toggles = 0;
    prevYellow = lampReadyYellow;
    for (int i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      #1;
      if (lampReadyYellow !== prevYellow) toggles++;
      prevYellow = lampReadyYellow;
    end
    check("yellowFlashing", 32'h1, 32'(toggles >= 2));
    check("lampReadyGreen", 32'h0, 32'(lampReadyGreen));
    finishTest();
  end
endmodule
`default_nettype wire
